//--- logic/wdr_pkg.sv
package wdr_pkg;
    // Byte offsets on the register bus
    localparam logic [7:0] WDR_OFF_CAUSE = 8'h00;
    localparam logic [7:0] WDR_OFF_WDCTL = 8'h04;
    localparam logic [7:0] WDR_OFF_AUX = 8'h08;
    localparam logic [7:0] WDR_OFF_STAT = 8'h0c;
    // Reset cause field positions
    localparam int WDR_B_POR = 0;
    localparam int WDR_B_PIN = 1;
    localparam int WDR_B_BOR = 2;
    localparam int WDR_B_WDT = 3;
    localparam int WDR_B_DBG = 4;
    // Watchdog control field positions
    localparam int WDR_B_PSEL = 0;
    localparam int WDR_B_EN = 3;
    localparam int WDR_B_UNLK = 4;
    // Aux control field positions
    localparam int WDR_B_COMPARATOR_BANDGAP_SELECT = 0;
    localparam int WDR_B_ADCEN = 1;
    localparam int WDR_B_RESTART = 2;
    // Reset values
    localparam logic [4:0] WDR_CAUSE_RST = 5'h01;
    localparam logic [2:0] WDR_PSEL_RST = 3'h0;
    // Unlock window, in system clock cycles
    localparam int WDR_UNLOCK_CYC = 4;
    // Watchdog oscillator, nominal
    localparam int WDR_WDOSC_KHZ = 1000;
    // Least time-out, 16K oscillator cycles
    localparam int WDR_BASE_LOG2 = 14;
    localparam int WDR_CNT_W = 22;
    // Default start-up delay, in microseconds, and its cycle count at 250 MHz
    localparam int WDR_STARTUP_US = 65;
    localparam int WDR_CLK_MHZ = 250;
    localparam int WDR_STARTUP_CYC = WDR_STARTUP_US * WDR_CLK_MHZ;
    typedef enum logic [1:0] {
        WDR_RUN = 2'b00,
        WDR_HOLD = 2'b01,
        WDR_DELAY = 2'b10
    } wdr_rst_st_t;
endpackage : wdr_pkg

//--- logic/wdr_wdt_core.sv
// Watchdog counter in its own oscillator domain
module wdr_wdt_core
    import wdr_pkg::*;
#(
    parameter int CNT_W = WDR_CNT_W
) (
    input wire logic wd_osc_clk,
    input wire logic rst,
    input wire logic enable_lvl,
    input wire logic [2:0] psel_lvl,
    input wire logic restart_tgl,
    output logic expire_tgl
);
    logic [2:0] en_s_r, en_s_nxt;
    logic [2:0] rs_s_r, rs_s_nxt;
    logic [2:0] p0_r, p1_r, p2_r;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic exp_r, exp_nxt;
    logic [2:0] psel;
    logic [CNT_W-1:0] limit;

    // Period limit doubles per select step
    function automatic logic [CNT_W-1:0] wdr_limit(input logic [2:0] s);
        wdr_limit = CNT_W'((64'd1 << (WDR_BASE_LOG2 + int'(s))) - 64'd1);
    endfunction : wdr_limit

    assign psel = p2_r;
    assign limit = wdr_limit(psel);
    assign expire_tgl = exp_r;

    always_comb begin
        en_s_nxt = {en_s_r[1:0], enable_lvl};
        rs_s_nxt = {rs_s_r[1:0], restart_tgl};
        cnt_nxt = cnt_r + CNT_W'(1);
        exp_nxt = exp_r;
        // Only agreeing stages count; stage 0 feeds stage 1 alone
        if (!(en_s_r[1] & en_s_r[2])) begin
            cnt_nxt = '0;
        end else if (rs_s_r[1] != rs_s_r[2]) begin
            cnt_nxt = '0;
        end else if (cnt_r >= limit) begin
            cnt_nxt = '0;
            exp_nxt = ~exp_r;
        end
    end

    // Counter runs only on the watchdog oscillator
    always_ff @(posedge wd_osc_clk or posedge rst) begin
        if (rst) begin
            en_s_r <= '0;
            rs_s_r <= '0;
            p0_r <= '0;
            p1_r <= '0;
            p2_r <= '0;
            cnt_r <= '0;
            exp_r <= 1'b0;
        end else begin
            en_s_r <= en_s_nxt;
            rs_s_r <= rs_s_nxt;
            // Period bus is quasi-static; last stage taken when stages agree
            p0_r <= psel_lvl;
            p1_r <= p0_r;
            p2_r <= (p1_r == p0_r) ? p1_r : p2_r;
            cnt_r <= cnt_nxt;
            exp_r <= exp_nxt;
        end
    end
endmodule : wdr_wdt_core

//--- logic/wdr_top.sv
// Notes on behaviour
// - Long low on reset pin resets without clock; start-up delay then releases. Here the pin is synchronised on core_clk, so the clock is needed.
// - Enabled brown-out indication resets at once; delay releases after recovery. Here it is synchronised on core_clk, so reset follows a few cycles later.
// - Watchdog time-out gives one-cycle reset pulse; delay starts at its end.
// - Watchdog counter runs from its own nominal 1 MHz oscillator.
// - Counter clears on restart, when disabled, and on any chip reset.
// - Enabled watchdog with no restart within period resets the device.
// - Period select picks 16K to 2048K oscillator cycles, doubling each step.
// - Fuse unprogrammed gives level 1 disabled; programmed gives level 2 enabled.
// - At level 1 writing enable one enables at once, no unlock.
// - At level 2 watchdog always enabled; enable bit reads one.
// - Level 2 period change uses unlock; enable value in second write ignored.
// - Hardware clears the unlock bit four system cycles after it is set.
// - Clearing enable or changing period needs unlock bit set.
// - Level 2 refuses disabling, even after full unlock sequence.
// - Control register bits 7 to 5 read as zero.
// - Debug-port reset flag set on debug reset; cleared by power-on or zero.
// - Watchdog reset flag set on watchdog reset; cleared by power-on or zero.
// - Brown-out reset flag set on brown-out reset; cleared by power-on or zero.
// - Pin reset flag set on pin reset; cleared by power-on or zero.
// - Power-on flag set on power-on reset; cleared only by writing zero.
// - Bandgap on when brown-out enabled, comparator select set, or converter on.
// - Device held in reset while debug reset register holds one.
//
// Design decisions made here: the AHB-Lite slave port and the address map.
module wdr_top
    import wdr_pkg::*;
#(
    parameter int STARTUP_CYC = WDR_STARTUP_CYC,
    parameter int CNT_W = WDR_CNT_W
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wd_osc_clk,
    input wire logic reset_pin_n,
    input wire logic brownout_low,
    input wire logic brownout_detector_en,
    input wire logic debug_reset_instruction,
    input wire logic wd_always_on_fuse_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic core_reset,
    output logic bandgap_enable,
    output logic io_reset
);
    localparam int SC_W = $clog2(STARTUP_CYC + 1);

    // Pin and brown-out inputs: three stages, act when last two agree
    logic [2:0] pin_s_r, pin_s_nxt;
    logic [2:0] bo_s_r, bo_s_nxt;
    logic pin_lvl_r, pin_lvl_nxt;
    logic bo_lvl_r, bo_lvl_nxt;
    // Watchdog expiry toggle from the oscillator domain
    logic [2:0] exp_s_r, exp_s_nxt;
    logic wd_pulse_r, wd_pulse_nxt;
    // Reset stretch state
    wdr_rst_st_t st_r, st_nxt;
    logic [SC_W-1:0] sc_r, sc_nxt;
    logic core_reset_r, core_reset_nxt;
    // Registers
    logic [4:0] cause_r, cause_nxt;
    logic wd_enable_bit_r, wd_enable_bit_nxt;
    logic wd_change_unlock_r, wd_change_unlock_nxt;
    logic [2:0] wd_psel_r, wd_psel_nxt;
    logic [2:0] unlk_cnt_r, unlk_cnt_nxt;
    logic comparator_bandgap_select_r, comparator_bandgap_select_nxt;
    logic adc_enable_r, adc_enable_nxt;
    logic restart_tgl_r, restart_tgl_nxt;
    logic bandgap_r, bandgap_nxt;
    logic level2_r, level2_nxt;
    logic fuse_taken_r, fuse_taken_nxt;
    logic wd_run_r, wd_run_nxt;
    // Bus
    logic dp_wr_r, dp_wr_nxt;
    logic [7:0] dp_addr_r, dp_addr_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic wd_exp_tgl;
    logic pin_rst, bo_rst, any_src;
    logic [7:0] wdctl_view;

    // Window in system cycles between the two unlock writes
    localparam logic [2:0] UNLK_LAST = 3'(WDR_UNLOCK_CYC);

    // Watchdog counter on its own oscillator
    wdr_wdt_core #(
        .CNT_W(CNT_W)
    ) wdr_wdt_core_i (
        .wd_osc_clk(wd_osc_clk),
        .rst(rst),
        .enable_lvl(wd_run_r),
        .psel_lvl(wd_psel_r),
        .restart_tgl(restart_tgl_r),
        .expire_tgl(wd_exp_tgl)
    );

    // Pin and brown-out levels pass core_clk synchronisers before acting
    assign pin_rst = ~reset_pin_n;
    assign bo_rst = brownout_low & brownout_detector_en;
    assign any_src = pin_lvl_r | bo_lvl_r | debug_reset_instruction;

    function automatic logic wdr_agree(input logic [2:0] s, input logic cur);
        wdr_agree = (s[1] == s[2]) ? s[2] : cur;
    endfunction : wdr_agree

    // Input synchronisers and watchdog pulse
    always_comb begin
        pin_s_nxt = {pin_s_r[1:0], pin_rst};
        bo_s_nxt = {bo_s_r[1:0], bo_rst};
        exp_s_nxt = {exp_s_r[1:0], wd_exp_tgl};
        pin_lvl_nxt = wdr_agree(pin_s_r, pin_lvl_r);
        bo_lvl_nxt = wdr_agree(bo_s_r, bo_lvl_r);
        wd_pulse_nxt = exp_s_r[1] ^ exp_s_r[2];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_s_r <= '0;
            bo_s_r <= '0;
            exp_s_r <= '0;
            pin_lvl_r <= 1'b0;
            bo_lvl_r <= 1'b0;
            wd_pulse_r <= 1'b0;
        end else begin
            pin_s_r <= pin_s_nxt;
            bo_s_r <= bo_s_nxt;
            exp_s_r <= exp_s_nxt;
            pin_lvl_r <= pin_lvl_nxt;
            bo_lvl_r <= bo_lvl_nxt;
            wd_pulse_r <= wd_pulse_nxt;
        end
    end

    // Reset stretch: hold while a source is active, then count the delay
    always_comb begin
        st_nxt = st_r;
        sc_nxt = sc_r;
        case (st_r)
            WDR_RUN: begin
                if (any_src || wd_pulse_r) begin
                    st_nxt = WDR_HOLD;
                end
            end
            WDR_HOLD: begin
                // Watchdog pulse lasts one cycle; delay starts as it falls
                if (!any_src) begin
                    st_nxt = WDR_DELAY;
                    sc_nxt = '0;
                end
            end
            WDR_DELAY: begin
                if (any_src) begin
                    st_nxt = WDR_HOLD;
                end else if (sc_r >= SC_W'(STARTUP_CYC - 1)) begin
                    st_nxt = WDR_RUN;
                end else begin
                    sc_nxt = sc_r + SC_W'(1);
                end
            end
            default: begin
                st_nxt = WDR_HOLD;
            end
        endcase
        core_reset_nxt = (st_nxt != WDR_RUN);
    end

    // Power-on reset enters the delay too
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_r <= WDR_DELAY;
            sc_r <= '0;
            core_reset_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            sc_r <= sc_nxt;
            core_reset_r <= core_reset_nxt;
        end
    end

    // Bus decode, registers and cause flags
    always_comb begin
        dp_wr_nxt = 1'b0;
        dp_addr_nxt = dp_addr_r;
        hrdata_nxt = hrdata_r;
        cause_nxt = cause_r;
        wd_enable_bit_nxt = wd_enable_bit_r;
        wd_change_unlock_nxt = wd_change_unlock_r;
        wd_psel_nxt = wd_psel_r;
        unlk_cnt_nxt = unlk_cnt_r;
        comparator_bandgap_select_nxt = comparator_bandgap_select_r;
        adc_enable_nxt = adc_enable_r;
        restart_tgl_nxt = restart_tgl_r;
        level2_nxt = level2_r;
        fuse_taken_nxt = 1'b1;
        // Fuse sampled once after release, not under reset
        if (!fuse_taken_r) begin
            level2_nxt = ~wd_always_on_fuse_n;
            wd_enable_bit_nxt = ~wd_always_on_fuse_n;
        end
        // Window counter; hardware drops the unlock bit after four cycles
        if (wd_change_unlock_r) begin
            if (unlk_cnt_r >= UNLK_LAST - 3'(1)) begin
                wd_change_unlock_nxt = 1'b0;
            end else begin
                unlk_cnt_nxt = unlk_cnt_r + 3'(1);
            end
        end
        if (hsel && hready && htrans[1]) begin
            dp_wr_nxt = hwrite;
            dp_addr_nxt = haddr[7:0];
        end
        if (dp_wr_r) begin
            case (dp_addr_r)
                WDR_OFF_CAUSE: begin
                    cause_nxt = cause_r & hwdata[4:0];
                end
                WDR_OFF_WDCTL: begin
                    if (hwdata[WDR_B_UNLK] && hwdata[WDR_B_EN]) begin
                        // First step opens the window
                        wd_change_unlock_nxt = 1'b1;
                        unlk_cnt_nxt = 3'h0;
                        wd_enable_bit_nxt = 1'b1;
                    end else if (wd_change_unlock_r) begin
                        wd_psel_nxt = hwdata[WDR_B_PSEL +: 3];
                        // Level 2 ignores the enable value
                        wd_enable_bit_nxt = hwdata[WDR_B_EN]
                            | level2_r;
                        wd_change_unlock_nxt = 1'b0;
                    end else if (hwdata[WDR_B_EN]) begin
                        wd_enable_bit_nxt = 1'b1;
                    end
                end
                WDR_OFF_AUX: begin
                    comparator_bandgap_select_nxt = hwdata[WDR_B_COMPARATOR_BANDGAP_SELECT];
                    adc_enable_nxt = hwdata[WDR_B_ADCEN];
                    if (hwdata[WDR_B_RESTART]) begin
                        restart_tgl_nxt = ~restart_tgl_r;
                    end
                end
                default: begin
                end
            endcase
        end
        if (level2_r) begin
            wd_enable_bit_nxt = 1'b1;
        end
        // Hardware sets win over a software clear in the same cycle
        if (debug_reset_instruction) cause_nxt[WDR_B_DBG] = 1'b1;
        if (wd_pulse_r) cause_nxt[WDR_B_WDT] = 1'b1;
        if (bo_lvl_r) cause_nxt[WDR_B_BOR] = 1'b1;
        if (pin_lvl_r) cause_nxt[WDR_B_PIN] = 1'b1;
        // Chip reset restores control fields, keeps cause flags
        if (core_reset_r && fuse_taken_r) begin
            wd_enable_bit_nxt = level2_r;
            wd_change_unlock_nxt = 1'b0;
            wd_psel_nxt = WDR_PSEL_RST;
            comparator_bandgap_select_nxt = 1'b0;
            adc_enable_nxt = 1'b0;
        end
        bandgap_nxt = brownout_detector_en | comparator_bandgap_select_nxt
            | adc_enable_nxt;
        // Counter held clear through any chip reset, level 2 included
        wd_run_nxt = wd_enable_bit_nxt & ~core_reset_nxt;
        wdctl_view = 8'h00;
        wdctl_view[WDR_B_PSEL +: 3] = wd_psel_nxt;
        wdctl_view[WDR_B_EN] = wd_enable_bit_nxt | level2_nxt;
        wdctl_view[WDR_B_UNLK] = wd_change_unlock_nxt;
        // Read word registered in the address phase so it stands for the
        // whole data phase; next values let a write just ahead be seen
        if (hsel && hready && htrans[1] && !hwrite) begin
            case (haddr[7:0])
                WDR_OFF_CAUSE: hrdata_nxt = {27'h0, cause_nxt};
                WDR_OFF_WDCTL: hrdata_nxt = {24'h0, wdctl_view};
                WDR_OFF_AUX: hrdata_nxt = {30'h0, adc_enable_nxt,
                    comparator_bandgap_select_nxt};
                WDR_OFF_STAT: hrdata_nxt = {29'h0, level2_nxt, bandgap_nxt,
                    core_reset_nxt};
                default: hrdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dp_wr_r <= 1'b0;
            wd_run_r <= 1'b0;
            dp_addr_r <= 8'h00;
            hrdata_r <= 32'h0;
            cause_r <= WDR_CAUSE_RST;
            wd_enable_bit_r <= 1'b0;
            wd_change_unlock_r <= 1'b0;
            wd_psel_r <= WDR_PSEL_RST;
            unlk_cnt_r <= 3'h0;
            comparator_bandgap_select_r <= 1'b0;
            adc_enable_r <= 1'b0;
            restart_tgl_r <= 1'b0;
            bandgap_r <= 1'b0;
            level2_r <= 1'b0;
            fuse_taken_r <= 1'b0;
        end else begin
            dp_wr_r <= dp_wr_nxt;
            wd_run_r <= wd_run_nxt;
            dp_addr_r <= dp_addr_nxt;
            hrdata_r <= hrdata_nxt;
            cause_r <= cause_nxt;
            wd_enable_bit_r <= wd_enable_bit_nxt;
            wd_change_unlock_r <= wd_change_unlock_nxt;
            wd_psel_r <= wd_psel_nxt;
            unlk_cnt_r <= unlk_cnt_nxt;
            comparator_bandgap_select_r <= comparator_bandgap_select_nxt;
            adc_enable_r <= adc_enable_nxt;
            restart_tgl_r <= restart_tgl_nxt;
            bandgap_r <= bandgap_nxt;
            level2_r <= level2_nxt;
            fuse_taken_r <= fuse_taken_nxt;
        end
    end

    // Zero-wait slave, always OKAY
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            io_reset <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            io_reset <= any_src | core_reset_r;
        end
    end

    assign hrdata = hrdata_r;
    assign core_reset = core_reset_r;
    assign bandgap_enable = bandgap_r;
endmodule : wdr_top

//--- test/wdr_chk_monitor.sv
module wdr_chk_monitor
    import wdr_pkg::*;
#(
    parameter int STARTUP_CYC = 20
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reset_pin_n,
    input wire logic brownout_low,
    input wire logic brownout_detector_en,
    input wire logic debug_reset_instruction,
    input wire logic wd_always_on_fuse_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic core_reset,
    input wire logic bandgap_enable,
    input wire logic io_reset
);
    timeunit 1ns;
    timeprecision 100ps;
    logic rd_q;
    logic [15:0] st_cnt;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // Control reads in data phase, and stretch length once no source drives
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_q <= 1'b0;
            st_cnt <= '0;
        end else begin
            rd_q <= hsel && hready && htrans[1] && !hwrite
                && haddr[7:0] == WDR_OFF_WDCTL;
            st_cnt <= (core_reset && reset_pin_n && !debug_reset_instruction
                && !(brownout_detector_en && brownout_low))
                ? st_cnt + 16'h1 : '0;
        end
    end
    sequence ctl_rd_s;
        rd_q && hready;
    endsequence
    sequence held_s;
        core_reset [*8];
    endsequence
    okay_resp_a: assert property (hsel && htrans[1] |=> !hresp && hreadyout)
        else $error("bus answer not zero-wait okay");
    pin_reset_a: assert property ($fell(reset_pin_n) |-> ##[1:6] core_reset)
        else $error("pin low did not reset core");
    bor_reset_a: assert property (brownout_detector_en && $rose(brownout_low)
        |-> ##[1:6] core_reset) else $error("brown-out did not reset core");
    dbg_hold_a: assert property (debug_reset_instruction [*3]
        |-> core_reset && io_reset) else $error("debug reset not held");
    delay_stretch_a: assert property ($rose(core_reset) |-> held_s)
        else $error("core released without start-up delay");
    delay_bound_a: assert property (st_cnt <= STARTUP_CYC + 8)
        else $error("start-up delay too long");
    bandgap_on_a: assert property (brownout_detector_en [*3] |-> bandgap_enable)
        else $error("bandgap off with brown-out enabled");
    reserved_zero_a: assert property (ctl_rd_s |-> hrdata[31:5] == 27'h0)
        else $error("control reserved bits not zero");
    level2_en_a: assert property (ctl_rd_s and !wd_always_on_fuse_n
        |-> hrdata[WDR_B_EN]) else $error("enable reads zero at level 2");
endmodule : wdr_chk_monitor

bind wdr_top wdr_chk_monitor #(
    .STARTUP_CYC(STARTUP_CYC)
) wdr_chk_monitor_i (
    .core_clk(core_clk), .rst(rst), .reset_pin_n(reset_pin_n),
    .brownout_low(brownout_low), .brownout_detector_en(brownout_detector_en),
    .debug_reset_instruction(debug_reset_instruction),
    .wd_always_on_fuse_n(wd_always_on_fuse_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .core_reset(core_reset),
    .bandgap_enable(bandgap_enable), .io_reset(io_reset)
);

//--- test/wdr_top_tb.sv
module wdr_top_tb
    import wdr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 0, rst = 1, wd_osc_clk = 0, reset_pin_n = 1;
    logic brownout_low = 0, brownout_detector_en = 0;
    logic debug_reset_instruction = 0, wd_always_on_fuse_n = 1;
    logic hsel = 0, hwrite = 0, hready, hreadyout, hresp;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, seed = 32'd97;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = 3'h2;
    logic core_reset, bandgap_enable, io_reset, rd_dp = 0;
    logic [31:0] exp_q[$];
    int err_count = 0, check_count = 0, cyc = 0, n = 0;
    // Oscillator sped up so the shortest period fits a short run
    always #2 core_clk = ~core_clk;
    always #1.5 wd_osc_clk = ~wd_osc_clk;
    assign hready = hreadyout;
    wdr_top #(.STARTUP_CYC(20)) wdr_top_i (
        .core_clk(core_clk), .rst(rst), .wd_osc_clk(wd_osc_clk),
        .reset_pin_n(reset_pin_n), .brownout_low(brownout_low),
        .brownout_detector_en(brownout_detector_en),
        .debug_reset_instruction(debug_reset_instruction),
        .wd_always_on_fuse_n(wd_always_on_fuse_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .core_reset(core_reset),
        .bandgap_enable(bandgap_enable), .io_reset(io_reset)
    );
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        check_count++;
        if (seen !== expv) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, expv);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    // One single word transfer; a read notes its expected data first
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        if (!w) exp_q.push_back(d);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge core_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= w ? d : rnd();
        do @(posedge core_clk); while (hready !== 1'b1);
    endtask : bus
    task automatic idle(input int k);
        repeat (k) @(posedge core_clk);
    endtask : idle
    // Bounded wait for the core reset level; n keeps the cycles taken
    task automatic wait_rst(input logic lvl, input int lim);
        n = 0;
        while (core_reset !== lvl && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        chk({31'h0, core_reset}, {31'h0, lvl});
    endtask : wait_rst
    // Read data is taken at the edge closing its data phase
    always @(posedge core_clk) begin
        if (rd_dp && hready === 1'b1) chk(hrdata, exp_q.pop_front());
        rd_dp <= hsel && htrans[1] && !hwrite && hready;
    end
    // Hang guard, well above the expected run length
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        wait_rst(1'b0, 60);
        bus(0, WDR_OFF_CAUSE, 32'h01);
        bus(0, WDR_OFF_WDCTL, 32'h00);
        bus(0, 8'h10, 32'h0);
        bus(1, WDR_OFF_CAUSE, 32'h0);
        bus(0, WDR_OFF_CAUSE, 32'h0);
        $display("reset state test done");
        bus(1, WDR_OFF_WDCTL, 32'h08);
        bus(0, WDR_OFF_WDCTL, 32'h08);
        bus(1, WDR_OFF_WDCTL, 32'h00);
        bus(0, WDR_OFF_WDCTL, 32'h08);
        bus(1, WDR_OFF_WDCTL, 32'h1b);
        bus(1, WDR_OFF_WDCTL, 32'h03);
        bus(0, WDR_OFF_WDCTL, 32'h03);
        bus(1, WDR_OFF_WDCTL, 32'h1b);
        idle(8);
        bus(0, WDR_OFF_WDCTL, 32'h0b);
        bus(1, WDR_OFF_WDCTL, 32'he0);
        bus(0, WDR_OFF_WDCTL, 32'h0b);
        $display("control test done");
        bus(1, WDR_OFF_WDCTL, 32'h18);
        bus(1, WDR_OFF_WDCTL, 32'h08);
        repeat (3) begin
            bus(1, WDR_OFF_AUX, 32'h04);
            idle(6000 + int'(rnd() & 32'hff));
        end
        bus(1, WDR_OFF_AUX, 32'h04);
        bus(0, WDR_OFF_CAUSE, 32'h0);
        // 16K oscillator cycles of 3 ns make 12288 core cycles
        wait_rst(1'b1, 13000);
        chk({31'h0, (n inside {[12100:12500]})}, 32'h1);
        wait_rst(1'b0, 60);
        bus(0, WDR_OFF_CAUSE, 32'h08);
        bus(0, WDR_OFF_WDCTL, 32'h00);
        bus(1, WDR_OFF_CAUSE, 32'h0);
        $display("watchdog test done");
        for (int i = 0; i < 3; i++) begin
            case (i)
                0: reset_pin_n <= 1'b0;
                1: begin
                    brownout_detector_en <= 1'b1;
                    brownout_low <= 1'b1;
                end
                default: debug_reset_instruction <= 1'b1;
            endcase
            idle(12);
            chk({30'h0, io_reset, core_reset}, 32'h3);
            reset_pin_n <= 1'b1;
            brownout_low <= 1'b0;
            debug_reset_instruction <= 1'b0;
            wait_rst(1'b0, 60);
            bus(0, WDR_OFF_CAUSE, i == 2 ? 32'h10 : 32'h2 << i);
            bus(1, WDR_OFF_CAUSE, 32'h0);
        end
        $display("reset source test done");
        for (int k = 0; k < 8; k++) begin
            brownout_detector_en <= k[2];
            bus(1, WDR_OFF_AUX, {30'h0, k[1], k[0]});
            idle(3);
            chk({31'h0, bandgap_enable}, {31'h0, |k[2:0]});
            bus(0, WDR_OFF_STAT, {30'h0, |k[2:0], 1'b0});
        end
        brownout_detector_en <= 1'b0;
        bus(1, WDR_OFF_AUX, 32'h0);
        $display("bandgap test done");
        wd_always_on_fuse_n <= 1'b0;
        rst <= 1'b1;
        idle(4);
        rst <= 1'b0;
        wait_rst(1'b0, 60);
        bus(0, WDR_OFF_CAUSE, 32'h01);
        bus(0, WDR_OFF_WDCTL, 32'h08);
        bus(1, WDR_OFF_WDCTL, 32'h00);
        bus(0, WDR_OFF_WDCTL, 32'h08);
        bus(1, WDR_OFF_WDCTL, 32'h18);
        bus(1, WDR_OFF_WDCTL, 32'h02);
        bus(0, WDR_OFF_WDCTL, 32'h0a);
        bus(0, WDR_OFF_STAT, 32'h04);
        $display("level two test done");
        print_verdict();
    end
endmodule : wdr_top_tb
